/* core/eba_pkg.sv */
/*
 Package of the external bus arbitration block: states, modes, reset values.
 Assumes one synchronous clock (the bus clock) for both ends.
*/
// Operation
// - three-wire mode: request out follows core need
// - request held until transfer actually starts
// - request may drop regardless of grant
// - request and driven outputs always actively driven
// - cycle starts no earlier than next edge
// - grant removed mid-cycle: finish, then release
// - arbiter drops grant before last acknowledge edge
// - burst or inhibited series is one cycle
// - granted with request: explicit, driven, start strobe
// - explicit and granted: keep driving bus
// - granted without request: implicit, bus undriven
// - implicit plus request: explicit at once
// - arbiter grants only after previous master released
// - done and ungranted: negate driven, float bus
// - request is only a status of need
// - end of cycle includes bus error termination
// - reset holds; exit to external or implicit
// - two-wire transition table
// - four states: reset, implicit, explicit, external
// - three-wire arbiter controls device via signals
// - two-wire: hold request drives grant; driven feeds ack
package eba_pkg;
	typedef enum logic [1:0] {
		EBA_RESET,
		EBA_IMPLICIT,
		EBA_EXPLICIT,
		EBA_EXTERNAL
	} eba_state_t;

	localparam logic       MODE_TWO_WIRE   = 1'h0;
	localparam logic       MODE_THREE_WIRE = 1'h1;
	localparam eba_state_t STATE_RST_VAL   = EBA_RESET;
	localparam logic [3:0] BEAT_CNT_RST    = 4'h0;
	localparam logic [3:0] HOST_HOLD_MIN   = 4'h2;
endpackage : eba_pkg

/* core/eba_if.sv */
/*
 Interface joining the device end and the arbiter/external master end.
 Assumes active-high logical signals; pin polarity is left to the pads.
*/
`timescale 1ns/1ns
`default_nettype none
interface eba_if;
	// arbitration wires
	logic bus_request;
	logic bus_driven;
	logic bus_grant;
	// shared bus activity
	logic transfer_start_strobe;
	logic transfer_acknowledge;
	logic bus_error;
	logic bus_drive_enable;

	modport dev (
		output bus_request,
		output bus_driven,
		input  bus_grant,
		output transfer_start_strobe,
		input  transfer_acknowledge,
		input  bus_error,
		output bus_drive_enable
	);
	modport arb (
		input  bus_request,
		input  bus_driven,
		output bus_grant,
		input  transfer_start_strobe,
		output transfer_acknowledge,
		output bus_error,
		input  bus_drive_enable
	);
endinterface : eba_if
`default_nettype wire

/* core/eba_next_state.sv */
/*
 Next-state decode of the four-state arbitration machine.
 Assumes registered inputs from the device end, sampled on bus clock.
*/
`timescale 1ns/1ns
`default_nettype none
module eba_next_state
	import eba_pkg::*;
(
	// current condition
	input  wire eba_pkg::eba_state_t state_in,
	input  wire logic                reset_any_in,
	input  wire logic                grant_in,
	input  wire logic                request_in,
	input  wire logic                in_progress_in,
	input  wire logic                end_cycle_in,
	// decision
	output eba_pkg::eba_state_t      next_state_out
);
	import eba_pkg::*;

	always_comb begin
		next_state_out = state_in;
		if (reset_any_in) begin
			next_state_out = EBA_RESET;
		end else begin
			case (state_in)
				EBA_RESET: begin
					next_state_out = grant_in ? EBA_IMPLICIT : EBA_EXTERNAL;
				end
				EBA_IMPLICIT: begin
					if (!grant_in)
						next_state_out = EBA_EXTERNAL;
					else if (request_in)
						next_state_out = EBA_EXPLICIT;
				end
				EBA_EXPLICIT: begin
					if (!grant_in && (!in_progress_in || end_cycle_in))
						next_state_out = EBA_EXTERNAL;
				end
				EBA_EXTERNAL: begin
					if (grant_in)
						next_state_out = request_in ? EBA_EXPLICIT : EBA_IMPLICIT;
				end
				default: next_state_out = EBA_RESET;
			endcase
		end
	end
endmodule : eba_next_state
`default_nettype wire

/* core/eba_device.sv */
/*
 Device end: tracks arbitration state, drives request, driven and start strobe.
 Assumes the core holds its request and burst flag until the cycle ends.
*/
`timescale 1ns/1ns
`default_nettype none
module eba_device
	import eba_pkg::*;
(
	// clock and resets
	input  wire logic  clk_in,
	input  wire logic  rst_in,
	input  wire logic  master_reset_in,
	input  wire logic  watchdog_reset_in,
	// configuration
	input  wire logic  three_wire_in,
	// core side
	input  wire logic  core_request_in,
	input  wire logic  core_burst_in,
	output logic       core_done_out,
	output logic       core_error_out,
	output eba_pkg::eba_state_t state_out,
	// link
	eba_if.dev         link
);
	import eba_pkg::*;

	eba_state_t state;
	eba_state_t next_state;
	logic       in_progress;
	logic       next_in_progress;
	logic       strobe;
	logic       next_strobe;
	logic       req;
	logic       next_req;
	logic       end_cycle;
	logic       last_beat;

	// end of the series: bus error, or acknowledge on the last beat (burst flag low)
	assign end_cycle = in_progress && (link.bus_error ||
		(link.transfer_acknowledge && !core_burst_in));
	assign last_beat = end_cycle;

	eba_next_state u_eba_next_state (
		.state_in       (state),
		.reset_any_in   (rst_in || master_reset_in || watchdog_reset_in),
		.grant_in       (link.bus_grant),
		.request_in     (core_request_in && !in_progress),
		.in_progress_in (in_progress),
		.end_cycle_in   (end_cycle),
		.next_state_out (next_state)
	);

	always_comb begin
		next_in_progress = in_progress;
		next_strobe      = 1'h0;
		next_req         = 1'h0;
		if (last_beat)
			next_in_progress = 1'h0;
		// start only from a grant seen on an earlier edge
		if (next_state == EBA_EXPLICIT && core_request_in && !in_progress
			&& state != EBA_RESET && link.bus_grant) begin
			next_strobe      = 1'h1;
			next_in_progress = 1'h1;
		end
		// need stays up until the strobe has gone out; may drop anytime
		if (three_wire_in && core_request_in && !in_progress && !next_strobe)
			next_req = 1'h1;
		if (state == EBA_RESET || next_state == EBA_RESET) begin
			next_in_progress = 1'h0;
			next_strobe      = 1'h0;
			next_req         = 1'h0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state       <= STATE_RST_VAL;
			in_progress <= 1'h0;
			strobe      <= 1'h0;
			req         <= 1'h0;
		end else begin
			state       <= next_state;
			in_progress <= next_in_progress;
			strobe      <= next_strobe;
			req         <= next_req;
		end
	end

	// always actively driven, never floated
	assign link.bus_request           = req;
	assign link.bus_driven            = (state == EBA_EXPLICIT);
	assign link.bus_drive_enable      = (state == EBA_EXPLICIT);
	assign link.transfer_start_strobe = strobe;
	assign core_done_out              = end_cycle && !link.bus_error;
	assign core_error_out             = in_progress && link.bus_error;
	assign state_out                  = state;
endmodule : eba_device
`default_nettype wire

/* core/eba_arbiter.sv */
/*
 Far end: external arbiter (three-wire) or hold-request master (two-wire).
 Grants the device only while no other master drives the bus.
*/
`timescale 1ns/1ns
`default_nettype none
module eba_arbiter
	import eba_pkg::*;
(
	// clock and reset
	input  wire logic clk_in,
	input  wire logic rst_in,
	// user side
	input  wire logic three_wire_in,
	input  wire logic other_need_in,
	input  wire logic other_driving_in,
	input  wire logic ack_in,
	input  wire logic error_in,
	output logic      hold_acknowledge_out,
	output logic      device_request_out,
	// link
	eba_if.arb        link
);
	import eba_pkg::*;

	logic grant;
	logic next_grant;

	always_comb begin
		next_grant = grant;
		// two-wire: grant only while neither hold request nor other master driving
		if (!three_wire_in)
			next_grant = !other_need_in && !other_driving_in;
		else if (other_need_in)
			next_grant = 1'h0;
		else
			next_grant = !other_driving_in;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in)
			grant <= 1'h0;
		else
			grant <= next_grant;
	end

	assign link.bus_grant            = grant;
	assign link.transfer_acknowledge = ack_in;
	assign link.bus_error            = error_in;
	assign hold_acknowledge_out      = link.bus_driven;
	assign device_request_out        = link.bus_request;
endmodule : eba_arbiter
`default_nettype wire

/* tb/eba_assertions.sv */
/*
 Checks on the arbitration link.
 Assumes one bus clock, sync high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module eba_assertions (
	// clock, reset, link
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic bus_request,
	input wire logic bus_driven,
	input wire logic bus_grant,
	input wire logic transfer_start_strobe,
	input wire logic transfer_acknowledge,
	input wire logic bus_error,
	input wire logic bus_drive_enable
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	sequence s_start;
		transfer_start_strobe;
	endsequence
	// start cycle with no termination yet
	sequence s_start_quiet;
		transfer_start_strobe && !transfer_acknowledge && !bus_error;
	endsequence
	start_grant_a: assert property (s_start |-> $past(bus_grant)) else $error("early start");
	start_driven_a: assert property (s_start |-> bus_driven) else $error("undriven");
	start_req_a: assert property (s_start |-> !bus_request) else $error("request kept");
	enable_match_a: assert property (bus_drive_enable == bus_driven) else $error("enable");
	release_ungrant_a: assert property ($fell(bus_driven) |-> !$past(bus_grant)) else $error("early release");
	granted_keep_a: assert property (bus_driven && bus_grant |=> bus_driven) else $error("dropped");
	start_holds_a: assert property (s_start_quiet |=> bus_driven)
		else $error("cycle cut");
	error_ends_a: assert property (bus_driven && bus_error && !bus_grant |=> !bus_driven) else $error("kept");
endmodule : eba_assertions
`default_nettype wire

/* tb/tb_external_bus_arbitration.sv */
/*
 Bench of both link ends.
 Inputs move 1 ns after edges.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_external_bus_arbitration;
	import eba_pkg::*;
	logic clk_in = 1'h0, rst_in = 1'h1;
	logic tw = 1'h0, rq = 1'h0, bu = 1'h0, nd = 1'h1, ak = 1'h0, er = 1'h0;
	logic od = 1'h0, ms = 1'h0, wd = 1'h0;
	wire logic hk, dr, dn, ce;
	eba_state_t st;
	int n_errors = 0, n_checks = 0;
	eba_if lk();
	wire logic [2:0] w = {lk.bus_grant, lk.transfer_start_strobe, lk.bus_driven};
	always #2 clk_in = ~clk_in;
	eba_device u_eba_device(.clk_in(clk_in), .rst_in(rst_in), .master_reset_in(ms), .watchdog_reset_in(wd),
		.three_wire_in(tw), .core_request_in(rq), .core_burst_in(bu), .core_done_out(dn), .core_error_out(ce),
		.state_out(st), .link(lk));
	eba_arbiter u_eba_arbiter(.clk_in(clk_in), .rst_in(rst_in), .three_wire_in(tw), .other_need_in(nd),
		.other_driving_in(od), .ack_in(ak), .error_in(er), .hold_acknowledge_out(hk),
		.device_request_out(dr), .link(lk));
	eba_assertions u_eba_assertions(.clk_in(clk_in), .rst_in(rst_in), .bus_request(lk.bus_request),
		.bus_driven(lk.bus_driven), .bus_grant(lk.bus_grant), .transfer_start_strobe(lk.transfer_start_strobe),
		.transfer_acknowledge(lk.transfer_acknowledge), .bus_error(lk.bus_error),
		.bus_drive_enable(lk.bus_drive_enable));
	task cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : cyc
	task chk(input logic [3:0] got, input logic [3:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t %h %h", $time, got, exp);
		end
	endtask : chk
	task close_out;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : close_out
	task till(input int b);
		for (int k = 0; k < 20 && w[b] !== 1'h1; k++) cyc(1);
		chk(w[b], 1'h1);
		if (w[b] !== 1'h1) close_out();
	endtask : till
	task t_exit;
		cyc(3);
		chk(st, EBA_EXTERNAL);
		nd = 1'h0;
		od = 1'h1;
		cyc(2);
		chk(w[2], 1'h0);
		od = 1'h0;
		till(2);
		cyc(2);
		chk({st, hk}, {EBA_IMPLICIT, 1'h0});
		$display("exit ok");
	endtask : t_exit
	task t_reset;
		ms = 1'h1;
		cyc(2);
		chk({st, hk, dr}, {EBA_RESET, 2'h0});
		ms = 1'h0;
		wd = 1'h1;
		cyc(1);
		chk(st, EBA_RESET);
		wd = 1'h0;
		cyc(1);
		chk(st, EBA_IMPLICIT);
		$display("reset ok");
	endtask : t_reset
	task t_burst;
		rq = 1'h1;
		bu = 1'h1;
		till(1);
		cyc(1);
		nd = 1'h1;
		ak = 1'h1;
		cyc(3);
		chk({lk.bus_driven, dn}, 2'h2);
		bu = 1'h0;
		#1;
		chk(dn, 1'h1);
		cyc(1);
		ak = 1'h0;
		rq = 1'h0;
		chk({st, hk}, {EBA_EXTERNAL, 1'h0});
		$display("burst ok");
	endtask : t_burst
	task t_three;
		tw = 1'h1;
		rq = 1'h1;
		cyc(3);
		chk({dr, w}, 4'h8);
		rq = 1'h0;
		cyc(1);
		chk(dr, 1'h0);
		rq = 1'h1;
		nd = 1'h0;
		till(1);
		chk({dr, w}, 4'h7);
		nd = 1'h1;
		cyc(3);
		er = 1'h1;
		#1;
		chk({ce, dn}, 2'h2);
		cyc(1);
		er = 1'h0;
		rq = 1'h0;
		chk(st, EBA_EXTERNAL);
		$display("three ok");
	endtask : t_three
	initial begin
		cyc(8);
		rst_in = 1'h0;
		t_exit();
		t_reset();
		t_burst();
		t_three();
		close_out();
	end
endmodule : tb_external_bus_arbitration
`default_nettype wire
